/* hdl/rtmts_params.svh */
// Purpose: Timing and index constants of the message transfer scheduler
// Assumes: 10 MHz system clock
// Notes: Times named _NS are in ns and cycle counts are derived from them; times named _CYC are given in clocks
`ifndef RTMTS_PARAMS_SVH
`define RTMTS_PARAMS_SVH

`define RTMTS_CLK_NS 100
`define RTMTS_CYC_UP(t) ((((t) + `RTMTS_CLK_NS - 1) / `RTMTS_CLK_NS))
`define RTMTS_CYC_DN(t) (((t) / `RTMTS_CLK_NS))

`define RTMTS_ADDR_MIN_NS 500
`define RTMTS_ADDR_MAX_NS 1100
`define RTMTS_SOM_MIN_NS 1250
`define RTMTS_SOM_MAX_NS 2100
`define RTMTS_RD_MIN_NS 1200
`define RTMTS_RD_MAX_NS 1600
`define RTMTS_EOMTX_MIN_NS 2800
`define RTMTS_EOMTX_MAX_NS 3200
`define RTMTS_WR_MIN_NS 1200
`define RTMTS_WR_MAX_NS 2000
`define RTMTS_EOMBC_MIN_NS 6700
`define RTMTS_EOMBC_MAX_NS 7400
`define RTMTS_RSP_MIN_NS 5900
`define RTMTS_RSP_MAX_NS 9400
`define RTMTS_RSP_FAST_NS 6900
`define RTMTS_ACK_MAX_NS 102
`define RTMTS_SUPERSEDE_CYC 5
`define RTMTS_LONG_SEQ_NS 2850
`define RTMTS_WORD_SEQ_CYC 4
`define RTMTS_RETRY_GAP_CYC 1

`define RTMTS_T_SOM 0
`define RTMTS_T_RD 1
`define RTMTS_T_WR 2
`define RTMTS_T_EOM 3
`define RTMTS_T_ADDR 4
`define RTMTS_T_RSP 5
`define RTMTS_NTMR 6
`define RTMTS_TMR_W 7
`define RTMTS_SEQ_W 8
`define RTMTS_WORD_W 16
`define RTMTS_ADDR_W 5
`define RTMTS_CFG_ILL_OFF_BIT 7

`endif

/* hdl/rtmts_pkg.sv */
// Purpose: Types of the message transfer scheduler
// Assumes: rtmts_params.svh supplies widths
// Notes: One-hot encodings are written out
`include "rtmts_params.svh"

package rtmts_pkg;

    typedef enum logic [2:0] {
        RTMTS_IDLE = 3'h1,
        RTMTS_REQ = 3'h2,
        RTMTS_XFER = 3'h4
    } rtmts_seq_t;

    typedef enum logic [3:0] {
        RTMTS_K_SOM = 4'h1,
        RTMTS_K_RD = 4'h2,
        RTMTS_K_WR = 4'h4,
        RTMTS_K_EOM = 4'h8
    } rtmts_kind_t;

    typedef struct packed {
        logic cmd_mp;
        logic cmd_tx;
        logic cmd_bcast;
        logic data_mp;
        logic data_last;
        logic tx_ms;
        logic tx_more;
        logic tx_last_mp;
    } rtmts_link_t;

    typedef struct packed {
        rtmts_seq_t seq;
        rtmts_kind_t kind;
        logic [`RTMTS_NTMR-1:0][`RTMTS_TMR_W-1:0] tmr;
        logic [3:0] pend;
        logic tx_msg;
        logic bcast_msg;
        logic [`RTMTS_SEQ_W-1:0] seq_cnt;
        logic req_n;
        logic ack_n;
        logic memen_n;
        logic illeg_rd;
        logic status_start;
        logic smp;
        logic [`RTMTS_ADDR_W-1:0] addr;
        logic addr_ok;
        logic [`RTMTS_WORD_W-1:0] tx_word;
        logic tx_word_vld;
    } rtmts_state_t;

endpackage : rtmts_pkg

/* hdl/rtmts_sync.sv */
// Purpose: Three-stage synchroniser for strapped pins
// Assumes: Inputs change rarely
// Notes: Output follows once stages two and three agree
`timescale 1ns/1ps
`default_nettype none

module rtmts_sync #(
    parameter int W = 6
) (
    input wire logic clk_i,
    input wire logic reset_i,
    input wire logic [W-1:0] async_i,
    output logic [W-1:0] stable_o
);
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
        logic [W-1:0] s3;
        logic [W-1:0] stable;
    } rtmts_sync_st_t;

    rtmts_sync_st_t st_ff;
    rtmts_sync_st_t nxt_st;

    always_comb begin
        nxt_st = st_ff;
        nxt_st.s1 = async_i;
        nxt_st.s2 = st_ff.s1;
        nxt_st.s3 = st_ff.s2;
        // Stage one feeds nothing but stage two
        if (st_ff.s2 == st_ff.s3) begin
            nxt_st.stable = st_ff.s3;
        end
    end

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign stable_o = st_ff.stable;
endmodule : rtmts_sync

`default_nettype wire

/* hdl/rtmts_buf.sv */
// Purpose: Two-entry buffer for received data words
// Assumes: Push and pop on the same clock
// Notes: Head word comes straight from a register
`timescale 1ns/1ps
`default_nettype none

module rtmts_buf #(
    parameter int W = 16
) (
    input wire logic clk_i,
    input wire logic reset_i,
    input wire logic in_valid_i,
    output logic in_ready_o,
    input wire logic [W-1:0] in_data_i,
    output logic out_valid_o,
    input wire logic out_ready_i,
    output logic [W-1:0] out_data_o
);
    typedef struct packed {
        logic [W-1:0] mem0;
        logic [W-1:0] mem1;
        logic [1:0] cnt;
    } rtmts_buf_st_t;

    rtmts_buf_st_t st_ff;
    rtmts_buf_st_t nxt_st;
    logic push;
    logic pop;

    assign in_ready_o = (st_ff.cnt != 2'h2);
    assign out_valid_o = (st_ff.cnt != 2'h0);
    assign push = in_valid_i && in_ready_o;
    assign pop = out_ready_i && out_valid_o;

    always_comb begin
        nxt_st = st_ff;
        if (push && pop) begin
            if (st_ff.cnt == 2'h1) begin
                nxt_st.mem0 = in_data_i;
            end else begin
                nxt_st.mem0 = st_ff.mem1;
                nxt_st.mem1 = in_data_i;
            end
        end else if (pop) begin
            nxt_st.mem0 = st_ff.mem1;
            nxt_st.cnt = st_ff.cnt - 2'h1;
        end else if (push) begin
            if (st_ff.cnt == 2'h0) begin
                nxt_st.mem0 = in_data_i;
            end else begin
                nxt_st.mem1 = in_data_i;
            end
            nxt_st.cnt = st_ff.cnt + 2'h1;
        end
    end

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign out_data_o = st_ff.mem0;
endmodule : rtmts_buf

`default_nettype wire

/* hdl/rtmts_top.sv */
// Purpose: Remote terminal message transfer scheduler
// Assumes: Link events are one-cycle pulses on clk_i
// Notes: Timers start at the documented minimum so late grants keep margin
`timescale 1ns/1ps
`default_nettype none
`include "rtmts_params.svh"

// Contract
// - Start the status reply between 5.9 and 9.4 us after the command, 6.9 us at most when buffered; the code starts it after transmit commands only.
// - Sample the five address straps and their parity 500 to 1100 ns after the command mid-parity.
// - For a transmit command drop the request 1.25 to 2.1 us after the command to ask for message start.
// - While transmitting, request the next word read 1.2 to 1.6 us after the current word's mid-sync.
// - After the last transmitted word request message end 2.8 to 3.2 us after its mid-parity.
// - In a broadcast receive request one word write 1.2 to 2.0 us after each data word mid-parity.
// - In a broadcast receive request message end 6.7 to 7.4 us after the last data word mid-parity.
// - A superseding command may stretch the message start delay by up to 5 clocks.
// - If message start overruns the first read, lift the request and drop it again one clock later.
// - Acknowledge within 102 ns after grant falls and take the memory.
// - Read the illegal command table during message start only when the disable bit is zero.
module rtmts_top #(
    parameter int LONG_SEQ = `RTMTS_CYC_UP(`RTMTS_LONG_SEQ_NS),
    parameter int WORD_SEQ = `RTMTS_WORD_SEQ_CYC
) (
    input wire logic clk_i,
    input wire logic reset_i,
    input wire rtmts_pkg::rtmts_link_t link_i,
    input wire logic [`RTMTS_ADDR_W-1:0] terminal_address_inputs_i,
    input wire logic terminal_address_parity_input_i,
    input wire logic [15:0] cfg3_i,
    input wire logic transfer_grant_n_i,
    input wire logic rx_valid_i,
    output logic rx_ready_o,
    input wire logic [`RTMTS_WORD_W-1:0] rx_data_i,
    input wire logic [`RTMTS_WORD_W-1:0] mem_rdata_i,
    output logic [`RTMTS_WORD_W-1:0] mem_wdata_o,
    output logic mem_wdata_valid_o,
    output logic transfer_request_n_o,
    output logic transfer_acknowledge_n_o,
    output logic memory_enable_out_n_o,
    output logic [3:0] seq_kind_o,
    output logic illegal_table_read_o,
    output logic status_start_o,
    output logic [`RTMTS_ADDR_W-1:0] terminal_address_o,
    output logic terminal_address_ok_o,
    output logic address_sampled_o,
    output logic [`RTMTS_WORD_W-1:0] tx_word_o,
    output logic tx_word_valid_o
);
    localparam int ADDR_LO = `RTMTS_CYC_UP(`RTMTS_ADDR_MIN_NS);
    localparam int ADDR_HI = `RTMTS_CYC_DN(`RTMTS_ADDR_MAX_NS);
    localparam int SOM_LO = `RTMTS_CYC_UP(`RTMTS_SOM_MIN_NS);
    localparam int SOM_HI = `RTMTS_CYC_DN(`RTMTS_SOM_MAX_NS) + `RTMTS_SUPERSEDE_CYC;
    localparam int RD_LO = `RTMTS_CYC_UP(`RTMTS_RD_MIN_NS);
    localparam int RD_HI = `RTMTS_CYC_DN(`RTMTS_RD_MAX_NS);
    localparam int WR_LO = `RTMTS_CYC_UP(`RTMTS_WR_MIN_NS);
    localparam int WR_HI = `RTMTS_CYC_DN(`RTMTS_WR_MAX_NS);
    localparam int ETX_LO = `RTMTS_CYC_UP(`RTMTS_EOMTX_MIN_NS);
    localparam int ETX_HI = `RTMTS_CYC_DN(`RTMTS_EOMTX_MAX_NS);
    localparam int EBC_LO = `RTMTS_CYC_UP(`RTMTS_EOMBC_MIN_NS);
    localparam int EBC_HI = `RTMTS_CYC_DN(`RTMTS_EOMBC_MAX_NS);
    localparam int RSP_LO = `RTMTS_CYC_UP(`RTMTS_RSP_MIN_NS);
    localparam int RSP_HI = `RTMTS_CYC_DN(`RTMTS_RSP_FAST_NS);
    localparam int ACK_HI = `RTMTS_CYC_DN(`RTMTS_ACK_MAX_NS);
    localparam int GAP = `RTMTS_RETRY_GAP_CYC;
    // Windows counted from the end of the quiet stretch after the command
    localparam int ADDR_LO_Q = ADDR_LO - 4;
    localparam int ADDR_HI_Q = ADDR_HI - 4;
    localparam int RSP_LO_Q = RSP_LO - 8;
    localparam int RSP_HI_Q = RSP_HI - 8;

    // Timer loads are one short: the fire cycle itself adds one; LONG_LD and WORD_LD load in full
    localparam logic [`RTMTS_TMR_W-1:0] ADDR_LD = `RTMTS_TMR_W'(ADDR_LO - 1);
    localparam logic [`RTMTS_TMR_W-1:0] SOM_LD = `RTMTS_TMR_W'(SOM_LO - 1);
    localparam logic [`RTMTS_TMR_W-1:0] RD_LD = `RTMTS_TMR_W'(RD_LO - 1);
    localparam logic [`RTMTS_TMR_W-1:0] WR_LD = `RTMTS_TMR_W'(WR_LO - 1);
    localparam logic [`RTMTS_TMR_W-1:0] ETX_LD = `RTMTS_TMR_W'(ETX_LO - 1);
    localparam logic [`RTMTS_TMR_W-1:0] EBC_LD = `RTMTS_TMR_W'(EBC_LO - 1);
    localparam logic [`RTMTS_TMR_W-1:0] RSP_LD = `RTMTS_TMR_W'(RSP_LO - 1);
    localparam logic [`RTMTS_SEQ_W-1:0] LONG_LD = `RTMTS_SEQ_W'(LONG_SEQ);
    localparam logic [`RTMTS_SEQ_W-1:0] WORD_LD = `RTMTS_SEQ_W'(WORD_SEQ);

    rtmts_pkg::rtmts_state_t st_ff;
    rtmts_pkg::rtmts_state_t nxt_st;
    logic [`RTMTS_ADDR_W:0] strap_stable;
    logic buf_valid;
    logic buf_pop;
    logic seq_last;

    rtmts_sync #(
        .W(`RTMTS_ADDR_W + 1)
    ) u_sync (
        .clk_i(clk_i),
        .reset_i(reset_i),
        .async_i({terminal_address_parity_input_i, terminal_address_inputs_i}),
        .stable_o(strap_stable)
    );

    // Receiver stalls through rx_ready_o when both entries wait for memory
    rtmts_buf #(
        .W(`RTMTS_WORD_W)
    ) u_buf (
        .clk_i(clk_i),
        .reset_i(reset_i),
        .in_valid_i(rx_valid_i),
        .in_ready_o(rx_ready_o),
        .in_data_i(rx_data_i),
        .out_valid_o(buf_valid),
        .out_ready_i(buf_pop),
        .out_data_o(mem_wdata_o)
    );

    assign seq_last = (st_ff.seq == rtmts_pkg::RTMTS_XFER) && (st_ff.seq_cnt == `RTMTS_SEQ_W'(1));
    assign buf_pop = seq_last && (st_ff.kind == rtmts_pkg::RTMTS_K_WR);

    always_comb begin
        logic [`RTMTS_NTMR-1:0] fire;
        logic [3:0] clr;
        logic [3:0] pick;
        fire = '0;
        clr = 4'h0;
        pick = st_ff.pend & (~st_ff.pend + 4'h1);
        nxt_st = st_ff;
        nxt_st.status_start = 1'b0;
        nxt_st.smp = 1'b0;
        nxt_st.illeg_rd = 1'b0;
        nxt_st.tx_word_vld = 1'b0;
        for (int i = 0; i < `RTMTS_NTMR; i++) begin
            fire[i] = (st_ff.tmr[i] == `RTMTS_TMR_W'(1));
            if (st_ff.tmr[i] != '0) begin
                nxt_st.tmr[i] = st_ff.tmr[i] - `RTMTS_TMR_W'(1);
            end
        end
        if (link_i.cmd_mp) begin
            // A new command drops whatever message timing was running
            nxt_st.tx_msg = link_i.cmd_tx;
            nxt_st.bcast_msg = link_i.cmd_bcast;
            nxt_st.tmr[`RTMTS_T_ADDR] = ADDR_LD;
            nxt_st.tmr[`RTMTS_T_SOM] = SOM_LD;
            nxt_st.tmr[`RTMTS_T_RSP] = link_i.cmd_tx ? RSP_LD : '0;
            nxt_st.tmr[`RTMTS_T_RD] = '0;
            nxt_st.tmr[`RTMTS_T_WR] = '0;
            nxt_st.tmr[`RTMTS_T_EOM] = '0;
        end else begin
            if (link_i.tx_ms && link_i.tx_more && st_ff.tx_msg) begin
                nxt_st.tmr[`RTMTS_T_RD] = RD_LD;
            end
            if (link_i.tx_last_mp && st_ff.tx_msg) begin
                nxt_st.tmr[`RTMTS_T_EOM] = ETX_LD;
            end
            if (link_i.data_mp && st_ff.bcast_msg) begin
                nxt_st.tmr[`RTMTS_T_WR] = WR_LD;
                if (link_i.data_last) begin
                    nxt_st.tmr[`RTMTS_T_EOM] = EBC_LD;
                end
            end
        end
        if (fire[`RTMTS_T_ADDR]) begin
            nxt_st.addr = strap_stable[`RTMTS_ADDR_W-1:0];
            nxt_st.addr_ok = ^strap_stable;
            nxt_st.smp = 1'b1;
        end
        if (fire[`RTMTS_T_RSP]) begin
            nxt_st.status_start = 1'b1;
        end
        case (st_ff.seq)
            rtmts_pkg::RTMTS_IDLE: begin
                // A waiting request drops one clock after the last one lifted
                if (st_ff.pend != 4'h0) begin
                    clr = pick;
                    nxt_st.kind = rtmts_pkg::rtmts_kind_t'(pick);
                    nxt_st.req_n = 1'b0;
                    nxt_st.seq = rtmts_pkg::RTMTS_REQ;
                end
            end
            rtmts_pkg::RTMTS_REQ: begin
                if (!transfer_grant_n_i) begin
                    nxt_st.ack_n = 1'b0;
                    nxt_st.memen_n = 1'b0;
                    nxt_st.seq = rtmts_pkg::RTMTS_XFER;
                    if (st_ff.kind == rtmts_pkg::RTMTS_K_SOM || st_ff.kind == rtmts_pkg::RTMTS_K_EOM) begin
                        nxt_st.seq_cnt = LONG_LD;
                    end else begin
                        nxt_st.seq_cnt = WORD_LD;
                    end
                    if (st_ff.kind == rtmts_pkg::RTMTS_K_SOM && !cfg3_i[`RTMTS_CFG_ILL_OFF_BIT]) begin
                        nxt_st.illeg_rd = 1'b1;
                    end
                end
            end
            rtmts_pkg::RTMTS_XFER: begin
                nxt_st.seq_cnt = st_ff.seq_cnt - `RTMTS_SEQ_W'(1);
                if (seq_last) begin
                    nxt_st.req_n = 1'b1;
                    nxt_st.ack_n = 1'b1;
                    nxt_st.memen_n = 1'b1;
                    nxt_st.seq = rtmts_pkg::RTMTS_IDLE;
                    if (st_ff.kind == rtmts_pkg::RTMTS_K_RD) begin
                        nxt_st.tx_word = mem_rdata_i;
                        nxt_st.tx_word_vld = 1'b1;
                    end
                end
            end
            default: begin
                nxt_st.seq = rtmts_pkg::RTMTS_IDLE;
                nxt_st.req_n = 1'b1;
                nxt_st.ack_n = 1'b1;
                nxt_st.memen_n = 1'b1;
            end
        endcase
        // A timer firing as its request is taken is kept
        nxt_st.pend = (st_ff.pend & ~clr) | fire[3:0];
    end

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            st_ff <= '0;
            st_ff.seq <= rtmts_pkg::RTMTS_IDLE;
            st_ff.kind <= rtmts_pkg::RTMTS_K_SOM;
            st_ff.req_n <= 1'b1;
            st_ff.ack_n <= 1'b1;
            st_ff.memen_n <= 1'b1;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign transfer_request_n_o = st_ff.req_n;
    assign transfer_acknowledge_n_o = st_ff.ack_n;
    assign memory_enable_out_n_o = st_ff.memen_n;
    assign seq_kind_o = st_ff.kind;
    assign mem_wdata_valid_o = buf_valid && (st_ff.kind == rtmts_pkg::RTMTS_K_WR) && !st_ff.ack_n;
    assign illegal_table_read_o = st_ff.illeg_rd;
    assign status_start_o = st_ff.status_start;
    assign terminal_address_o = st_ff.addr;
    assign terminal_address_ok_o = st_ff.addr_ok;
    assign address_sampled_o = st_ff.smp;
    assign tx_word_o = st_ff.tx_word;
    assign tx_word_valid_o = st_ff.tx_word_vld;

    sequence s_cmd_tx;
        link_i.cmd_mp && link_i.cmd_tx;
    endsequence

    sequence s_quiet_cmd;
        !link_i.cmd_mp [*8];
    endsequence

    sequence s_quiet_short;
        !link_i.cmd_mp [*4];
    endsequence

    AST_RSP: assert property (@(posedge clk_i) disable iff (reset_i)
        s_cmd_tx ##1 s_quiet_cmd |-> ##[RSP_LO_Q:RSP_HI_Q] status_start_o)
        else $error("status start out of window");
    AST_ADDR: assert property (@(posedge clk_i) disable iff (reset_i)
        link_i.cmd_mp ##1 s_quiet_short |-> ##[ADDR_LO_Q:ADDR_HI_Q] address_sampled_o)
        else $error("address straps not sampled in window");
    AST_SOM: assert property (@(posedge clk_i) disable iff (reset_i)
        link_i.cmd_mp |-> ##[SOM_LO:SOM_HI] st_ff.pend[`RTMTS_T_SOM])
        else $error("message start request late");
    AST_RD: assert property (@(posedge clk_i) disable iff (reset_i)
        link_i.tx_ms && link_i.tx_more && st_ff.tx_msg && !link_i.cmd_mp
        |-> ##[RD_LO:RD_HI] st_ff.pend[`RTMTS_T_RD])
        else $error("word read request out of window");
    AST_ETX: assert property (@(posedge clk_i) disable iff (reset_i)
        link_i.tx_last_mp && st_ff.tx_msg && !link_i.cmd_mp
        |-> ##[ETX_LO:ETX_HI] st_ff.pend[`RTMTS_T_EOM])
        else $error("transmit end request out of window");
    AST_WR: assert property (@(posedge clk_i) disable iff (reset_i)
        link_i.data_mp && st_ff.bcast_msg && !link_i.cmd_mp
        |-> ##[WR_LO:WR_HI] st_ff.pend[`RTMTS_T_WR])
        else $error("word write request out of window");
    AST_EBC: assert property (@(posedge clk_i) disable iff (reset_i)
        link_i.data_mp && link_i.data_last && st_ff.bcast_msg && !link_i.cmd_mp
        |-> ##[EBC_LO:EBC_HI] st_ff.pend[`RTMTS_T_EOM])
        else $error("broadcast end request out of window");
    AST_RETRY: assert property (@(posedge clk_i) disable iff (reset_i)
        $rose(transfer_request_n_o) && (st_ff.pend != 4'h0) |-> ##GAP $fell(transfer_request_n_o))
        else $error("queued request not reissued after one clock");
    AST_ACK: assert property (@(posedge clk_i) disable iff (reset_i)
        st_ff.seq == rtmts_pkg::RTMTS_REQ && !transfer_grant_n_i
        |-> ##ACK_HI !transfer_acknowledge_n_o && !memory_enable_out_n_o)
        else $error("acknowledge late after grant");
    AST_ILL: assert property (@(posedge clk_i) disable iff (reset_i)
        illegal_table_read_o |-> seq_kind_o == rtmts_pkg::RTMTS_K_SOM && $past(!cfg3_i[`RTMTS_CFG_ILL_OFF_BIT]))
        else $error("illegal table read while disabled");
    AST_END: assert property (@(posedge clk_i) disable iff (reset_i)
        $rose(transfer_request_n_o) |-> transfer_acknowledge_n_o && memory_enable_out_n_o
        && $past(!transfer_acknowledge_n_o))
        else $error("request lifted apart from acknowledge");
    AST_HOLD: assert property (@(posedge clk_i) disable iff (reset_i)
        !transfer_acknowledge_n_o || !memory_enable_out_n_o |-> !transfer_request_n_o)
        else $error("request lifted before sequence");
endmodule : rtmts_top

`default_nettype wire

/* verification/rtmts_arbiter_model.sv */
// Purpose: Memory arbiter on the far side of the transfer handshake
// Assumes: Grant is active low, released high while idle
// Notes: Grant latency set by delay_i in clocks, zero means prompt
`timescale 1ns/1ps
`default_nettype none

module rtmts_arbiter_model (
    input wire logic clk_i,
    input wire logic transfer_request_n_i,
    input wire logic transfer_acknowledge_n_i,
    input wire logic [7:0] delay_i,
    output logic transfer_grant_n_o
);
    logic [7:0] cnt;

    initial begin
        transfer_grant_n_o = 1'b1;
        cnt = 8'h00;
    end

    // Released once acknowledge falls, zero hold is allowed
    always @(negedge clk_i) begin
        if (!transfer_acknowledge_n_i || transfer_request_n_i) begin
            transfer_grant_n_o <= 1'b1;
            cnt <= 8'h00;
        end else if (cnt >= delay_i) begin
            transfer_grant_n_o <= 1'b0;
        end else begin
            cnt <= cnt + 8'h01;
        end
    end
endmodule : rtmts_arbiter_model

`default_nettype wire

/* verification/rtmts_top_tb_top.sv */
// Purpose: Scenario bench of the message transfer scheduler
// Assumes: 10 MHz clock, inputs driven on the falling edge
// Notes: Latencies counted in rising edges from the link pulse
`timescale 1ns/1ps
`default_nettype none

module rtmts_top_tb_top;
    logic clk, reset, gnt_n, rx_valid, rx_ready, req_n, ack_n, memen_n, wvld, ill, stat, asmp, aok, tvld;
    rtmts_pkg::rtmts_link_t link;
    logic [15:0] cfg3, rx_data, wdata, tword, exp_w;
    logic [4:0] taddr;
    logic [3:0] kind;
    logic [7:0] dly;
    int errors, samples_checked, cyc, t_addr, t_stat, ill_cnt;

    rtmts_top u_rtmts_top (.clk_i(clk), .reset_i(reset), .link_i(link), .terminal_address_inputs_i(5'h0B),
        .terminal_address_parity_input_i(1'b0), .cfg3_i(cfg3), .transfer_grant_n_i(gnt_n),
        .rx_valid_i(rx_valid), .rx_ready_o(rx_ready), .rx_data_i(rx_data), .mem_rdata_i(16'hA5C3),
        .mem_wdata_o(wdata), .mem_wdata_valid_o(wvld), .transfer_request_n_o(req_n),
        .transfer_acknowledge_n_o(ack_n), .memory_enable_out_n_o(memen_n), .seq_kind_o(kind),
        .illegal_table_read_o(ill), .status_start_o(stat), .terminal_address_o(taddr),
        .terminal_address_ok_o(aok), .address_sampled_o(asmp), .tx_word_o(tword), .tx_word_valid_o(tvld));

    rtmts_arbiter_model u_rtmts_arbiter_model (.clk_i(clk), .transfer_request_n_i(req_n),
        .transfer_acknowledge_n_i(ack_n), .delay_i(dly), .transfer_grant_n_o(gnt_n));

    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    // Stamps taken one edge after the registered pulse
    always @(posedge clk) begin
        cyc++;
        if (asmp === 1'b1) t_addr = cyc;
        if (stat === 1'b1) t_stat = cyc;
        if (ill === 1'b1) ill_cnt++;
    end

    task tally_and_finish;
        $display("errors=%0d samples_checked=%0d", errors, samples_checked);
        if (errors == 0 && samples_checked > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : tally_and_finish

    task chk(input logic [31:0] seen, input logic [31:0] exp, input string msg);
        samples_checked++;
        if (seen !== exp) begin
            errors++;
            $display("BAD %0t %s", $time, msg);
        end
    endtask : chk

    task hang;
        errors++;
        $display("BAD %0t wait ran out", $time);
        tally_and_finish;
    endtask : hang

    task pulse(input rtmts_pkg::rtmts_link_t v, output int t);
        @(negedge clk);
        link = v;
        @(negedge clk);
        link = '0;
        t = cyc;
    endtask : pulse

    task req_fall(input int t, input int lo, input int hi, input string m);
        int n;
        for (n = 0; req_n !== 1'b0; n++) begin
            if (n > 100) hang;
            @(posedge clk);
            #1;
        end
        chk(32'(cyc - t >= lo && cyc - t <= hi), 32'h1, m);
    endtask : req_fall

    task finish_seq(input logic [3:0] k);
        int n;
        n = 0;
        while (gnt_n !== 1'b0) begin
            if (++n > 60) hang;
            @(negedge clk);
            #1;
        end
        @(posedge clk);
        #1;
        chk({ack_n, memen_n, kind}, {2'b00, k}, "ack late or wrong kind");
        if (k == rtmts_pkg::RTMTS_K_WR) chk({wvld, wdata}, {1'b1, exp_w}, "write word");
        for (n = 0; req_n === 1'b0; n++) begin
            if (n > 60) hang;
            chk({ack_n, memen_n}, 2'b00, "ack dropped early");
            @(posedge clk);
            #1;
        end
        chk({ack_n, memen_n}, 2'b11, "release not together");
    endtask : finish_seq

    task sc_transmit;
        int tb0, tc, tm;
        cfg3 = 16'h0000;
        pulse(8'hA0, tb0);
        repeat (4) @(negedge clk);
        pulse(8'hC0, tc);
        req_fall(tc, 13, 26, "start request time");
        pulse(8'h06, tm);
        finish_seq(rtmts_pkg::RTMTS_K_SOM);
        @(posedge clk);
        #1;
        chk(req_n, 1'b0, "no retry after one clock");
        finish_seq(rtmts_pkg::RTMTS_K_RD);
        chk({tvld, tword}, {1'b1, 16'hA5C3}, "read word");
        pulse(8'h06, tm);
        req_fall(tm, 12, 16, "read request time");
        finish_seq(rtmts_pkg::RTMTS_K_RD);
        pulse(8'h01, tm);
        req_fall(tm, 28, 32, "end request time");
        finish_seq(rtmts_pkg::RTMTS_K_EOM);
        chk(32'(t_addr - tc >= 5 && t_addr - tc <= 11), 32'h1, "address sample time");
        chk({aok, taddr}, {1'b1, 5'h0B}, "address value");
        chk(32'(t_stat - tc >= 59 && t_stat - tc <= 69), 32'h1, "reply time");
        chk(ill_cnt, 1, "table read enabled");
    endtask : sc_transmit

    task sc_broadcast;
        int tc, t1, t2;
        cfg3 = 16'h0080;
        pulse(8'hA0, tc);
        req_fall(tc, 13, 21, "start request time");
        finish_seq(rtmts_pkg::RTMTS_K_SOM);
        @(negedge clk);
        rx_valid = 1'b1;
        rx_data = 16'h1234;
        @(negedge clk);
        rx_data = 16'h5678;
        @(negedge clk);
        rx_data = 16'h9ABC;
        chk(rx_ready, 1'b0, "buffer not full");
        @(negedge clk);
        rx_valid = 1'b0;
        // Slow grant keeps the full buffer stalled a while
        dly = 8'd20;
        exp_w = 16'h1234;
        pulse(8'h10, t1);
        req_fall(t1, 12, 20, "write request time");
        finish_seq(rtmts_pkg::RTMTS_K_WR);
        chk(rx_ready, 1'b1, "no room after pop");
        exp_w = 16'h5678;
        pulse(8'h18, t2);
        req_fall(t2, 12, 20, "last write time");
        finish_seq(rtmts_pkg::RTMTS_K_WR);
        req_fall(t2, 67, 74, "end request time");
        finish_seq(rtmts_pkg::RTMTS_K_EOM);
        chk(ill_cnt, 1, "table read while disabled");
    endtask : sc_broadcast

    initial begin
        reset = 1'b1;
        link = '0;
        cfg3 = 16'h0000;
        rx_valid = 1'b0;
        rx_data = 16'h0000;
        dly = 8'h00;
        repeat (3) @(negedge clk);
        reset = 1'b0;
        chk({req_n, ack_n, memen_n, rx_ready}, 4'hF, "idle after reset");
        repeat (6) @(negedge clk);
        sc_transmit;
        sc_broadcast;
        tally_and_finish;
    end
endmodule : rtmts_top_tb_top

`default_nettype wire
